// ==== hdl/fcs_config_bits.sv ====
`timescale 1ns/1ps
module fcs_config_bits (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic low_vcc,
   input wire logic status_write_ok,
   output fcs_pkg::fcs_cfg_t cfg,
   output fcs_pkg::fcs_pwr_out_t pwr,
   output logic [fcs_pkg::NUM_BLOCKS-1:0] block_lock,
   output logic [fcs_pkg::NUM_BLOCKS-1:0] block_protect
);

   logic [1:0] sck_sync_q;
   logic [1:0] cs_sync_q;
   logic [1:0] mosi_sync_q;
   logic [1:0] vcc_sync_q;
   logic sck_prev_q;
   logic cs_prev_q;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic cs_fall;
   logic cs_active;
   logic [5:0] bit_cnt_q;
   logic [31:0] frame_q;
   logic [7:0] cmd_q;
   logic [7:0] tx_q;
   logic tx_en_q;
   logic [1:0] drv_q;
   logic scheme_q;
   logic depth_q;
   logic wen_latch_q;
   logic op_wren;
   logic op_wrdi;
   logic op_wrsr_any;
   logic op_wrsr_three;
   logic op_wrsr_four;
   logic op_lock;
   logic op_unlock;
   logic op_deep;
   logic op_ultra;
   logic op_wake;
   logic [fcs_pkg::NUM_BLOCKS-1:0] lock_q;
   fcs_pkg::fcs_pwr_t pwr_q;
   fcs_pkg::fcs_pwr_t pwr_d;
   logic buf_clear_q;
   logic [7:0] reg_three;
   logic [7:0] reg_four;
   logic awake;
   logic end_cmd;
   logic end_data;
   logic end_addr;
   logic wr_allow;
   logic [fcs_pkg::BLOCK_ADDR_W-1:0] blk_idx;
   logic [8:0] pct;

   // Pins from the host cross into clk through two flops each
   // Chip select resets high so no false frame start follows reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sck_sync_q <= 2'h0;
         cs_sync_q <= 2'h3;
         mosi_sync_q <= 2'h0;
         vcc_sync_q <= 2'h0;
      end else if (ce) begin
         sck_sync_q <= {sck_sync_q[0], spi_sck};
         cs_sync_q <= {cs_sync_q[0], spi_cs_n};
         mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
         vcc_sync_q <= {vcc_sync_q[0], low_vcc};
      end
   end

   // Edge history taken from the second stage only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else if (ce) begin
         sck_prev_q <= sck_sync_q[1];
         cs_prev_q <= cs_sync_q[1];
      end
   end

   // Edges qualified by chip select; sck is ignored between frames
   assign cs_active = ~cs_sync_q[1];
   assign sck_rise = cs_active & sck_sync_q[1] & ~sck_prev_q;
   assign sck_fall = cs_active & ~sck_sync_q[1] & sck_prev_q;
   assign cs_rise = cs_sync_q[1] & ~cs_prev_q;
   assign cs_fall = ~cs_sync_q[1] & cs_prev_q;

   // Mode 0 receive: sample on rising sck, count saturates
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bit_cnt_q <= 6'h00;
         frame_q <= 32'h0000_0000;
         cmd_q <= 8'h00;
      end else if (ce) begin
         if (cs_fall) begin
            bit_cnt_q <= 6'h00;
         end else if (sck_rise) begin
            frame_q <= {frame_q[30:0], mosi_sync_q[1]};
            if (bit_cnt_q != 6'h3F) begin
               bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            if (bit_cnt_q == fcs_pkg::BITS_CMD - 6'h01) begin
               cmd_q <= {frame_q[6:0], mosi_sync_q[1]};
            end
         end
      end
   end

   // Readable images; unmodeled and reserved bits read zero
   always_comb begin
      reg_three = 8'h00;
      reg_three[fcs_pkg::DRV_LSB +: 2] = drv_q;
      reg_three[fcs_pkg::SCHEME_BIT] = scheme_q;
      reg_four = 8'h00;
      reg_four[fcs_pkg::DEPTH_BIT] = depth_q;
   end

   // Only the awake state answers reads and writes
   assign awake = (pwr_q == fcs_pkg::FCS_PWR_ON);

   // Transmit on falling sck; reload each byte so reads repeat
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_q <= 8'h00;
         tx_en_q <= 1'b0;
      end else if (ce) begin
         if (cs_rise || cs_fall) begin
            tx_en_q <= 1'b0;
         end else if (sck_fall && bit_cnt_q >= fcs_pkg::BITS_CMD && bit_cnt_q[2:0] == 3'h0) begin
            if (awake && cmd_q == fcs_pkg::CMD_RDSR_THREE) begin
               tx_q <= reg_three;
               tx_en_q <= 1'b1;
            end else if (awake && cmd_q == fcs_pkg::CMD_RDSR_FOUR) begin
               tx_q <= reg_four;
               tx_en_q <= 1'b1;
            end
         end else if (sck_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // Output straight from the shift flop; enable drops with chip select
   assign spi_miso = tx_q[7];
   assign spi_miso_oe = tx_en_q & cs_active;

   // Frame end qualifiers: exact bit counts only
   assign end_cmd = cs_rise && bit_cnt_q == fcs_pkg::BITS_CMD;
   assign end_data = cs_rise && bit_cnt_q == fcs_pkg::BITS_CMD_DATA;
   assign end_addr = cs_rise && bit_cnt_q == fcs_pkg::BITS_CMD_ADDR;
   assign wr_allow = awake & wen_latch_q & status_write_ok;
   assign blk_idx = frame_q[fcs_pkg::BLOCK_ADDR_LSB +: fcs_pkg::BLOCK_ADDR_W];

   // Command decode, each qualified by its own exact frame length
   assign op_wren = end_cmd && cmd_q == fcs_pkg::CMD_WRITE_ENABLE;
   assign op_wrdi = end_cmd && cmd_q == fcs_pkg::CMD_WRITE_DISABLE;
   assign op_wrsr_three = end_data && cmd_q == fcs_pkg::CMD_WRSR_THREE;
   assign op_wrsr_four = end_data && cmd_q == fcs_pkg::CMD_WRSR_FOUR;
   assign op_wrsr_any = end_data && (cmd_q == fcs_pkg::CMD_WRSR_ONE || cmd_q == fcs_pkg::CMD_WRSR_TWO ||
                        cmd_q == fcs_pkg::CMD_WRSR_THREE || cmd_q == fcs_pkg::CMD_WRSR_FOUR);
   assign op_lock = end_addr && cmd_q == fcs_pkg::CMD_BLOCK_LOCK;
   assign op_unlock = end_addr && cmd_q == fcs_pkg::CMD_BLOCK_UNLOCK;
   assign op_deep = end_cmd && cmd_q == fcs_pkg::CMD_DEEP_SLEEP;
   assign op_ultra = end_cmd && cmd_q == fcs_pkg::CMD_ULTRA_SLEEP;
   assign op_wake = end_cmd && cmd_q == fcs_pkg::CMD_WAKE;

   // Write enable latch; any permitted write-status drops it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wen_latch_q <= 1'b0;
      end else if (ce && awake) begin
         if (op_wren) begin
            wen_latch_q <= 1'b1;
         end else if (op_wrdi) begin
            wen_latch_q <= 1'b0;
         end else if (op_wrsr_any && wr_allow) begin
            wen_latch_q <= 1'b0;
         end
      end
   end

   // Register three: drive and scheme; reserved write bits dropped
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         drv_q <= fcs_pkg::DRV_RESET;
         scheme_q <= fcs_pkg::SCHEME_RESET;
      end else if (ce && op_wrsr_three && wr_allow) begin
         drv_q <= frame_q[fcs_pkg::DRV_LSB +: 2];
         scheme_q <= frame_q[fcs_pkg::SCHEME_BIT];
      end
   end

   // Register four: power-down depth
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         depth_q <= fcs_pkg::DEPTH_RESET;
      end else if (ce && op_wrsr_four && wr_allow) begin
         depth_q <= frame_q[fcs_pkg::DEPTH_BIT];
      end
   end

   // Block locks: all set at reset, edited only in per-block scheme
   // Address bits above the eight blocks are ignored, so higher addresses alias onto the eight locks
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_q <= '1;
      end else if (ce && awake && scheme_q) begin
         if (op_lock) begin
            lock_q[blk_idx] <= 1'b1;
         end else if (op_unlock) begin
            lock_q[blk_idx] <= 1'b0;
         end
      end
   end

   // Range scheme leaves block guarding to the range logic outside
   assign block_lock = lock_q;
   assign block_protect = scheme_q ? lock_q : '0;

   // Power state; a sleeping device only decodes the wake command
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         fcs_pkg::FCS_PWR_ON: begin
            if (op_ultra) begin
               pwr_d = fcs_pkg::FCS_PWR_ULTRA;
            end else if (op_deep) begin
               pwr_d = depth_q ? fcs_pkg::FCS_PWR_DEEP : fcs_pkg::FCS_PWR_ULTRA;
            end
         end
         fcs_pkg::FCS_PWR_DEEP, fcs_pkg::FCS_PWR_ULTRA: begin
            // Bare chip-select pulses give no 8-bit ABh frame
            if (op_wake) begin
               pwr_d = fcs_pkg::FCS_PWR_ON;
            end
         end
         default: begin
            pwr_d = fcs_pkg::FCS_PWR_ON;
         end
      endcase
   end

   // Power state flop; reset always lands awake
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pwr_q <= fcs_pkg::FCS_PWR_ON;
      end else if (ce) begin
         pwr_q <= pwr_d;
      end
   end

   // One-cycle buffer wipe on entering ultra-deep sleep
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         buf_clear_q <= 1'b0;
      end else if (ce) begin
         buf_clear_q <= (pwr_d == fcs_pkg::FCS_PWR_ULTRA) && (pwr_q != fcs_pkg::FCS_PWR_ULTRA);
      end
   end

   // Effective drive; reserved code drives as full, safest for the bus
   always_comb begin
      case (drv_q)
         fcs_pkg::DRV_TWO_THIRDS: pct = vcc_sync_q[1] ? fcs_pkg::PCT_TWO_THIRDS_LOW : fcs_pkg::PCT_TWO_THIRDS;
         fcs_pkg::DRV_ONE_THIRD: pct = vcc_sync_q[1] ? fcs_pkg::PCT_ONE_THIRD_LOW : fcs_pkg::PCT_ONE_THIRD;
         fcs_pkg::DRV_FULL: pct = vcc_sync_q[1] ? fcs_pkg::PCT_FULL_LOW : fcs_pkg::PCT_FULL;
         default: pct = vcc_sync_q[1] ? fcs_pkg::PCT_FULL_LOW : fcs_pkg::PCT_FULL;
      endcase
   end

   // Configuration fields for the rest of the device
   assign cfg.drive_strength_sel = drv_q;
   assign cfg.drive_level_pct = pct;
   assign cfg.protect_scheme_sel = scheme_q;
   assign cfg.use_range_protect = ~scheme_q;
   assign cfg.power_down_depth_sel = depth_q;
   assign cfg.write_enable_latch = wen_latch_q;

   // Sleep depth and buffer handling
   assign pwr.deep_sleep = (pwr_q == fcs_pkg::FCS_PWR_DEEP);
   assign pwr.ultra_deep_sleep = (pwr_q == fcs_pkg::FCS_PWR_ULTRA);
   assign pwr.buffer_keep = (pwr_q != fcs_pkg::FCS_PWR_ULTRA);
   assign pwr.buffer_clear = buf_clear_q;

endmodule // fcs_config_bits

// ==== hdl/fcs_pkg.sv ====
package fcs_pkg;

   // Command codes shifted in on the serial input
   localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_WRSR_ONE = 8'h01;
   localparam logic [7:0] CMD_WRSR_TWO = 8'h31;
   localparam logic [7:0] CMD_WRSR_THREE = 8'h11;
   localparam logic [7:0] CMD_WRSR_FOUR = 8'h71;
   localparam logic [7:0] CMD_RDSR_THREE = 8'h15;
   localparam logic [7:0] CMD_RDSR_FOUR = 8'h25;
   localparam logic [7:0] CMD_BLOCK_LOCK = 8'h36;
   localparam logic [7:0] CMD_BLOCK_UNLOCK = 8'h39;
   localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
   localparam logic [7:0] CMD_ULTRA_SLEEP = 8'h79;
   localparam logic [7:0] CMD_WAKE = 8'hAB;

   // Frame lengths in bits
   localparam logic [5:0] BITS_CMD = 6'h08;
   localparam logic [5:0] BITS_CMD_DATA = 6'h10;
   localparam logic [5:0] BITS_CMD_ADDR = 6'h20;

   // Field positions in the third and fourth status registers
   localparam int DRV_LSB = 5;
   localparam int SCHEME_BIT = 2;
   localparam int DEPTH_BIT = 7;

   // Reset values
   localparam logic [1:0] DRV_RESET = 2'h1;
   localparam logic SCHEME_RESET = 1'b0;
   localparam logic DEPTH_RESET = 1'b0;

   // Drive strength codes
   localparam logic [1:0] DRV_RESERVED = 2'h0;
   localparam logic [1:0] DRV_FULL = 2'h1;
   localparam logic [1:0] DRV_TWO_THIRDS = 2'h2;
   localparam logic [1:0] DRV_ONE_THIRD = 2'h3;

   // Effective drive in percent of full strength, nominal and low supply
   localparam logic [8:0] PCT_FULL = 9'h064;
   localparam logic [8:0] PCT_FULL_LOW = 9'h0A6;
   localparam logic [8:0] PCT_TWO_THIRDS = 9'h042;
   localparam logic [8:0] PCT_TWO_THIRDS_LOW = 9'h084;
   localparam logic [8:0] PCT_ONE_THIRD = 9'h021;
   localparam logic [8:0] PCT_ONE_THIRD_LOW = 9'h063;

   // Block lock layout: 64 KB blocks over a 512 KB array
   localparam int NUM_BLOCKS = 8;
   localparam int BLOCK_ADDR_LSB = 16;
   localparam int BLOCK_ADDR_W = 3;

   typedef enum logic [2:0] {
      FCS_PWR_ON = 3'b001,
      FCS_PWR_DEEP = 3'b010,
      FCS_PWR_ULTRA = 3'b100
   } fcs_pwr_t;

   // Configuration seen by the rest of the device
   typedef struct packed {
      logic [1:0] drive_strength_sel;
      logic [8:0] drive_level_pct;
      logic protect_scheme_sel;
      logic use_range_protect;
      logic power_down_depth_sel;
      logic write_enable_latch;
   } fcs_cfg_t;

   // Power state seen by the rest of the device
   typedef struct packed {
      logic deep_sleep;
      logic ultra_deep_sleep;
      logic buffer_keep;
      logic buffer_clear;
   } fcs_pwr_out_t;

endpackage

// ==== test/fcs_config_bits_properties.sv ====
`timescale 1ns/1ps
// Pin-level checks on the config bits block
module fcs_config_bits_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic spi_cs_n,
   input wire logic low_vcc,
   input wire logic status_write_ok,
   input wire fcs_pkg::fcs_cfg_t cfg,
   input wire fcs_pkg::fcs_pwr_out_t pwr,
   input wire logic [7:0] block_lock,
   input wire logic [7:0] block_protect
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Expected drive percent for a code and supply state
   function automatic logic [8:0] pct_of(input logic [1:0] c, input logic lo);
      case (c)
         fcs_pkg::DRV_TWO_THIRDS: return lo ? fcs_pkg::PCT_TWO_THIRDS_LOW : fcs_pkg::PCT_TWO_THIRDS;
         fcs_pkg::DRV_ONE_THIRD: return lo ? fcs_pkg::PCT_ONE_THIRD_LOW : fcs_pkg::PCT_ONE_THIRD;
         default: return lo ? fcs_pkg::PCT_FULL_LOW : fcs_pkg::PCT_FULL;
      endcase
   endfunction
   // Supply flag is synchronised, so let it settle first
   a_drive_nominal: assert property ((!low_vcc)[*4] |-> cfg.drive_level_pct == pct_of(cfg.drive_strength_sel, 1'b0))
      else $error("nominal drive level wrong");
   a_drive_low: assert property (low_vcc[*4] |-> cfg.drive_level_pct == pct_of(cfg.drive_strength_sel, 1'b1))
      else $error("low supply drive level wrong");
   a_range_select: assert property (cfg.use_range_protect == !cfg.protect_scheme_sel)
      else $error("range select not inverse of scheme");
   a_block_select: assert property (block_protect == (cfg.protect_scheme_sel ? block_lock : 8'h00))
      else $error("block protect mismatch");
   a_reset_values: assert property ($fell(sys_rst) |-> block_lock == 8'hFF && cfg.drive_strength_sel == 2'h1)
      else $error("reset values wrong");
   // Reset edge itself changes state, so skip the first edge after it
   a_lock_change: assert property (!$past(sys_rst) && $changed(block_lock) |-> cfg.protect_scheme_sel && $past(spi_cs_n, 3))
      else $error("lock bits moved without command");
   a_buffer_keep: assert property (pwr.buffer_keep == !pwr.ultra_deep_sleep && !(pwr.deep_sleep && pwr.ultra_deep_sleep))
      else $error("buffer keep or sleep state wrong");
   a_clear_pulse: assert property ($rose(pwr.ultra_deep_sleep) |-> pwr.buffer_clear ##1 !pwr.buffer_clear)
      else $error("buffer clear pulse wrong");
   a_wake_frame: assert property (!$past(sys_rst) && $fell(pwr.deep_sleep || pwr.ultra_deep_sleep) |-> $past(spi_cs_n, 3))
      else $error("woke outside a frame");
   a_status_write: assert property (!$past(sys_rst) && $changed({cfg.drive_strength_sel, cfg.protect_scheme_sel,
      cfg.power_down_depth_sel}) |-> $past(cfg.write_enable_latch) && $past(status_write_ok))
      else $error("status changed without write enable");
endmodule // fcs_config_bits_properties
bind fcs_config_bits fcs_config_bits_properties u_props (.clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
   .low_vcc(low_vcc), .status_write_ok(status_write_ok), .cfg(cfg), .pwr(pwr), .block_lock(block_lock),
   .block_protect(block_protect));

// ==== test/fcs_spi_host.sv ====
`timescale 1ns/1ps
// Mode 0 host; sck high for five clocks and low for ten keeps the pin synchronisers happy
module fcs_spi_host (
   input wire logic clk,
   output logic sck,
   output logic cs_n,
   output logic mosi,
   input wire logic miso,
   output logic rd_valid,
   output logic [7:0] rd_byte
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      rd_valid = 1'b0;
      rd_byte = 8'h00;
   end
   // One frame, MSB first from bit 31; read data captured after the command byte
   task automatic frame(input logic [31:0] v, input int n, input logic rd);
      @(posedge clk) cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (5) @(posedge clk);
         mosi <= v[31-i];
         repeat (5) @(posedge clk);
         sck <= 1'b1;
         if (rd && i >= 8) rd_byte <= {rd_byte[6:0], miso};
         repeat (5) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (5) @(posedge clk);
      cs_n <= 1'b1;
      mosi <= ~mosi; // Released line must not hold its last value
      rd_valid <= rd;
      @(posedge clk) rd_valid <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule // fcs_spi_host

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   logic clk, sys_rst, low_vcc, status_write_ok, sck, cs_n, mosi, miso, miso_oe, rd_valid;
   logic oe_seen = 1'b0;
   logic [7:0] rd_byte, lock, prot, e;
   logic [7:0] exp_q[$];
   logic [2:0] b;
   logic [1:0] c;
   int p, mismatches, check_count;
   fcs_pkg::fcs_cfg_t cfg;
   fcs_pkg::fcs_pwr_out_t pwr;
   fcs_config_bits DUT (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso), .spi_miso_oe(miso_oe), .low_vcc(low_vcc), .status_write_ok(status_write_ok), .cfg(cfg),
      .pwr(pwr), .block_lock(lock), .block_protect(prot));
   fcs_spi_host host (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .rd_valid(rd_valid),
      .rd_byte(rd_byte));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic ok(input logic v);
      check_count++;
      return v;
   endfunction
   task automatic err(input string m);
      mismatches++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task automatic complete_run;
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmd8(input logic [7:0] op);
      host.frame({op, 24'h00_0000}, 8, 1'b0);
   endtask
   task automatic wrsr(input logic [7:0] op, input logic [7:0] d);
      cmd8(fcs_pkg::CMD_WRITE_ENABLE);
      host.frame({op, d, 16'h0000}, 16, 1'b0);
   endtask
   // Expected byte is noted before the read goes out
   task automatic rdsr(input logic [7:0] op, input logic [7:0] x);
      exp_q.push_back(x);
      host.frame({op, 24'h00_0000}, 16, 1'b1);
   endtask
   // Read monitor takes the oldest note; the output must have been driven
   always @(posedge clk) begin
      if (miso_oe === 1'b1) oe_seen = 1'b1;
      if (rd_valid === 1'b1) begin
         e = exp_q.pop_front();
         if (!ok(rd_byte === e)) err("read back mismatch");
         if (!ok(oe_seen === 1'b1)) err("read data not driven");
         oe_seen = 1'b0;
      end
   end
   initial begin
      repeat (80000) @(posedge clk);
      err("watchdog expired");
      complete_run;
   end
   initial begin
      sys_rst = 1'b1;
      low_vcc = 1'b0;
      status_write_ok = 1'b1;
      e = 8'($urandom(32'habcc_18d9));
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdsr(fcs_pkg::CMD_RDSR_THREE, 8'h20);
      rdsr(fcs_pkg::CMD_RDSR_FOUR, 8'h00);
      if (!ok(lock === 8'hFF && prot === 8'h00)) err("lock reset");
      // Drive codes 1 to 3 with random reserved bits, then both supply states
      for (int i = 1; i < 4; i++) begin
         c = i[1:0];
         wrsr(fcs_pkg::CMD_WRSR_THREE, {1'b0, c, 5'h00} | (8'($urandom) & 8'h9B));
         rdsr(fcs_pkg::CMD_RDSR_THREE, {1'b0, c, 5'h00});
         for (int v = 0; v < 2; v++) begin
            low_vcc <= v[0];
            repeat (6) @(posedge clk);
            p = (c == 2'h1) ? (v ? 166 : 100) : (c == 2'h2 ? 66 : 33) * (v ? int'(c) : 1);
            if (!ok(cfg.drive_level_pct === 9'(p))) err("drive level");
         end
      end
      // No write enable, then write enable without permission
      host.frame({fcs_pkg::CMD_WRSR_THREE, 8'h20, 16'h0000}, 16, 1'b0);
      status_write_ok <= 1'b0;
      wrsr(fcs_pkg::CMD_WRSR_THREE, 8'h20);
      status_write_ok <= 1'b1;
      if (!ok(cfg.drive_strength_sel === 2'h3 && cfg.write_enable_latch === 1'b1)) err("write refused");
      b = 3'($urandom);
      host.frame({fcs_pkg::CMD_BLOCK_UNLOCK, 5'h00, b, 16'h0000}, 32, 1'b0);
      if (!ok(lock === 8'hFF)) err("unlock in range mode");
      wrsr(fcs_pkg::CMD_WRSR_THREE, 8'h64);
      if (!ok(prot === 8'hFF && cfg.use_range_protect === 1'b0)) err("block scheme");
      host.frame({fcs_pkg::CMD_BLOCK_UNLOCK, 5'h00, b, 16'h0000}, 32, 1'b0);
      if (!ok(prot === ~(8'h01 << b))) err("unlock");
      host.frame({fcs_pkg::CMD_BLOCK_LOCK, 5'h00, b, 16'h0000}, 32, 1'b0);
      if (!ok(lock === 8'hFF)) err("lock");
      host.frame({fcs_pkg::CMD_BLOCK_UNLOCK, 5'h00, b, 16'h0000}, 32, 1'b0);
      // Deep command at both depths, ultra command, bare toggles and refused commands asleep
      for (int k = 0; k < 3; k++) begin
         wrsr(fcs_pkg::CMD_WRSR_FOUR, k ? 8'h80 : 8'h00);
         rdsr(fcs_pkg::CMD_RDSR_FOUR, k ? 8'h80 : 8'h00);
         cmd8(k == 2 ? fcs_pkg::CMD_ULTRA_SLEEP : fcs_pkg::CMD_DEEP_SLEEP);
         host.frame(32'h0000_0000, 0, 1'b0);
         cmd8(fcs_pkg::CMD_WRITE_ENABLE);
         if (!ok(pwr.ultra_deep_sleep === (k != 1) && pwr.deep_sleep === (k == 1) && pwr.buffer_keep === (k == 1)
            && cfg.write_enable_latch === 1'b0)) err("sleep state");
         cmd8(fcs_pkg::CMD_WAKE);
         if (!ok(pwr.deep_sleep === 1'b0 && pwr.ultra_deep_sleep === 1'b0)) err("wake");
      end
      // Reset in mid-run relocks every block
      sys_rst <= 1'b1;
      @(posedge clk) sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      if (!ok(lock === 8'hFF && cfg.drive_strength_sel === 2'h1 && cfg.power_down_depth_sel === 1'b0)) err("reset");
      complete_run;
   end
endmodule // tb_top
